// [hdl/dsp_pkg.sv]
package dsp_pkg;
  // Register indices on the plain register port
  localparam logic [3:0] DSP_REG_CTRL   = 4'h0;
  localparam logic [3:0] DSP_REG_CNT    = 4'h1;
  localparam logic [3:0] DSP_REG_CMPA   = 4'h2;
  localparam logic [3:0] DSP_REG_CMPB   = 4'h3;
  localparam logic [3:0] DSP_REG_CAPTOP = 4'h4;
  localparam logic [3:0] DSP_REG_FLAGS  = 4'h5;
  localparam logic [3:0] DSP_REG_DIR    = 4'h6;

  // Control field positions
  localparam int DSP_CTRL_WGM_LSB  = 0;
  localparam int DSP_CTRL_COMA_LSB = 4;
  localparam int DSP_CTRL_COMB_LSB = 6;
  localparam int DSP_CTRL_PRE_LSB  = 8;

  // Flag bit positions
  localparam int DSP_FLG_OVF  = 0;
  localparam int DSP_FLG_CMPA = 1;
  localparam int DSP_FLG_CMPB = 2;
  localparam int DSP_FLG_CAP  = 3;

  // Waveform modes
  localparam logic [3:0] DSP_WGM_PC8   = 4'h1;
  localparam logic [3:0] DSP_WGM_PC9   = 4'h2;
  localparam logic [3:0] DSP_WGM_PC10  = 4'h3;
  localparam logic [3:0] DSP_WGM_PFC_C = 4'h8;
  localparam logic [3:0] DSP_WGM_PFC_A = 4'h9;
  localparam logic [3:0] DSP_WGM_PC_C  = 4'hA;
  localparam logic [3:0] DSP_WGM_PC_A  = 4'hB;

  localparam logic [15:0] DSP_TOP8    = 16'h00FF;
  localparam logic [15:0] DSP_TOP9    = 16'h01FF;
  localparam logic [15:0] DSP_TOP10   = 16'h03FF;
  localparam logic [15:0] DSP_BOTTOM  = 16'h0000;
  localparam logic [15:0] DSP_RST16   = 16'h0000;

  // Compare output modes
  localparam logic [1:0] DSP_COM_OFF = 2'h0;
  localparam logic [1:0] DSP_COM_TGL = 2'h1;
  localparam logic [1:0] DSP_COM_NIN = 2'h2;
  localparam logic [1:0] DSP_COM_INV = 2'h3;

  // Prescale selects and divide counts
  localparam logic [2:0] DSP_PRE_STOP = 3'h0;
  localparam logic [2:0] DSP_PRE_1    = 3'h1;
  localparam logic [2:0] DSP_PRE_8    = 3'h2;
  localparam logic [2:0] DSP_PRE_64   = 3'h3;
  localparam logic [2:0] DSP_PRE_256  = 3'h4;
  localparam logic [2:0] DSP_PRE_1024 = 3'h5;
  localparam logic [9:0] DSP_DIV8_M1    = 10'h007;
  localparam logic [9:0] DSP_DIV64_M1   = 10'h03F;
  localparam logic [9:0] DSP_DIV256_M1  = 10'h0FF;
  localparam logic [9:0] DSP_DIV1024_M1 = 10'h3FF;
endpackage : dsp_pkg

// [hdl/dsp_prescaler.sv]
module dsp_prescaler
  import dsp_pkg::*;
(
  input  wire logic       ref_clk,
  input  wire logic       resetn,
  input  wire logic       clk_en,
  input  wire logic [2:0] pre_sel,
  output logic            timer_tick
);
  logic [9:0] div_r;
  logic [9:0] limit;
  logic       running;
  logic       wrap;

  assign limit   = (pre_sel == DSP_PRE_8)    ? DSP_DIV8_M1 :
                   (pre_sel == DSP_PRE_64)   ? DSP_DIV64_M1 :
                   (pre_sel == DSP_PRE_256)  ? DSP_DIV256_M1 :
                   (pre_sel == DSP_PRE_1024) ? DSP_DIV1024_M1 : 10'h000;
  assign running = (pre_sel >= DSP_PRE_1) && (pre_sel <= DSP_PRE_1024);
  assign wrap    = div_r >= limit;
  assign timer_tick = clk_en && running && wrap;

  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      div_r <= 10'h000;
    end else if (clk_en) begin
      div_r <= (!running || wrap) ? 10'h000 : div_r + 10'h001;
    end
  end
endmodule : dsp_prescaler

// [hdl/dsp_timer.sv]
// The placing of the registers and the plain strobed port were chosen for this implementation.
module dsp_timer
  import dsp_pkg::*;
(
  input  wire logic        ref_clk,
  input  wire logic        resetn,
  input  wire logic        clk_en,
  input  wire logic [3:0]  reg_addr,
  input  wire logic [15:0] reg_wdata,
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  output logic [15:0]      reg_rdata,
  output logic             compare_output_a,
  output logic             compare_output_a_oe,
  output logic             compare_output_b,
  output logic             compare_output_b_oe
);
  import dsp_pkg::*;

  logic [15:0] ctrl_r;
  logic [15:0] counter_value_r;
  logic        down_r;
  logic [15:0] cmp_a_buf_r;
  logic [15:0] cmp_b_buf_r;
  logic [15:0] compare_a_value_r;
  logic [15:0] compare_b_value_r;
  logic [15:0] capture_top_value_r;
  logic [3:0]  flags_r;
  logic [1:0]  pin_direction_bit_r;
  logic [1:0]  oc_r;
  logic [15:0] reg_rdata_r;
  logic        oc_a_pin_r;
  logic        oc_b_pin_r;
  logic        oe_a_r;
  logic        oe_b_r;

  logic [3:0]  waveform_mode;
  logic [1:0]  com_a;
  logic [1:0]  com_b;
  logic [2:0]  pre_sel;
  logic        timer_tick;
  logic        mode_pc;
  logic        mode_pfc;
  logic        dual;
  logic        top_from_a;
  logic        top_from_cap;
  logic [15:0] top_val;
  logic [15:0] wmask;
  logic        at_top;
  logic        at_bottom;
  logic        upd_pc;
  logic        upd_pfc;
  logic        upd;
  logic [15:0] cnt_nxt;
  logic        down_nxt;
  logic        cnt_dn;
  logic        wr_ctrl;
  logic        wr_cnt;
  logic        wr_cmpa;
  logic        wr_cmpb;
  logic        wr_cap;
  logic        wr_flags;
  logic        wr_dir;
  logic [15:0] cmp_val    [2];
  logic [1:0]  com_sel    [2];
  logic [1:0]  match;
  logic [1:0]  conn;
  logic [1:0]  oc_nxt;
  logic [3:0]  flag_set;
  logic [3:0]  flags_nxt;
  logic [15:0] rdata_nxt;

  assign waveform_mode = ctrl_r[DSP_CTRL_WGM_LSB +: 4];
  assign com_a         = ctrl_r[DSP_CTRL_COMA_LSB +: 2];
  assign com_b         = ctrl_r[DSP_CTRL_COMB_LSB +: 2];
  assign pre_sel       = ctrl_r[DSP_CTRL_PRE_LSB +: 3];

  dsp_prescaler u_pre (
    .ref_clk    (ref_clk),
    .resetn     (resetn),
    .clk_en     (clk_en),
    .pre_sel    (pre_sel),
    .timer_tick (timer_tick)
  );

  assign mode_pc = (waveform_mode == DSP_WGM_PC8) || (waveform_mode == DSP_WGM_PC9) ||
                   (waveform_mode == DSP_WGM_PC10) || (waveform_mode == DSP_WGM_PC_C) ||
                   (waveform_mode == DSP_WGM_PC_A);
  assign mode_pfc = (waveform_mode == DSP_WGM_PFC_C) || (waveform_mode == DSP_WGM_PFC_A);
  assign dual     = mode_pc || mode_pfc;
  assign top_from_a   = (waveform_mode == DSP_WGM_PC_A) || (waveform_mode == DSP_WGM_PFC_A);
  assign top_from_cap = (waveform_mode == DSP_WGM_PC_C) || (waveform_mode == DSP_WGM_PFC_C);

  assign top_val = (waveform_mode == DSP_WGM_PC8)  ? DSP_TOP8 :
                   (waveform_mode == DSP_WGM_PC9)  ? DSP_TOP9 :
                   (waveform_mode == DSP_WGM_PC10) ? DSP_TOP10 :
                   top_from_a ? compare_a_value_r : capture_top_value_r;
  assign wmask = (waveform_mode == DSP_WGM_PC8)  ? DSP_TOP8 :
                 (waveform_mode == DSP_WGM_PC9)  ? DSP_TOP9 :
                 (waveform_mode == DSP_WGM_PC10) ? DSP_TOP10 : 16'hFFFF;

  assign at_top    = dual && (counter_value_r == top_val);
  assign at_bottom = dual && (counter_value_r == DSP_BOTTOM);
  assign upd_pc  = timer_tick && mode_pc && at_top;
  assign upd_pfc = timer_tick && mode_pfc && at_bottom;
  assign upd     = upd_pc || upd_pfc;

  // at TOP count down on the next tick; at bottom count up
  assign down_nxt = at_top ? 1'b1 : (at_bottom ? 1'b0 : down_r);
  assign cnt_nxt  = !dual ? counter_value_r :
                    at_top ? (counter_value_r - 16'h0001) :
                    at_bottom ? (counter_value_r + 16'h0001) :
                    down_r ? (counter_value_r - 16'h0001) : (counter_value_r + 16'h0001);

  assign wr_ctrl  = reg_wr && (reg_addr == DSP_REG_CTRL);
  assign wr_cnt   = reg_wr && (reg_addr == DSP_REG_CNT);
  assign wr_cmpa  = reg_wr && (reg_addr == DSP_REG_CMPA);
  assign wr_cmpb  = reg_wr && (reg_addr == DSP_REG_CMPB);
  assign wr_cap   = reg_wr && (reg_addr == DSP_REG_CAPTOP);
  assign wr_flags = reg_wr && (reg_addr == DSP_REG_FLAGS);
  assign wr_dir   = reg_wr && (reg_addr == DSP_REG_DIR);

  // Bottom counts as the upward turn so a zero compare keeps its idle level
  assign cnt_dn = at_top || (down_r && !at_bottom);

  assign cmp_val[0] = compare_a_value_r;
  assign cmp_val[1] = compare_b_value_r;
  assign com_sel[0] = com_a;
  assign com_sel[1] = com_b;

  genvar gi;
  generate
    for (gi = 0; gi < 2; gi++) begin : g_ch
      // match on equality; compare above TOP never equals
      assign match[gi] = timer_tick && dual && (counter_value_r == cmp_val[gi]);
      // disconnect unless PWM, or toggle on A with A-defined TOP
      assign conn[gi] = (com_sel[gi] == DSP_COM_NIN) || (com_sel[gi] == DSP_COM_INV) ||
                        ((gi == 0) && (com_sel[gi] == DSP_COM_TGL) && top_from_a);
      // clear up, set down, inverse for mode 3
      // extremes fall out of match at bottom and TOP
      // toggle on match for square wave
      assign oc_nxt[gi] = !(match[gi] && conn[gi] && dual) ? oc_r[gi] :
                          (com_sel[gi] == DSP_COM_TGL) ? ~oc_r[gi] :
                          (com_sel[gi] == DSP_COM_NIN) ? cnt_dn :
                          !cnt_dn;
    end
  endgenerate

  // overflow at bottom in phase correct and PFC modes
  assign flag_set[DSP_FLG_OVF]  = timer_tick && at_bottom;
  assign flag_set[DSP_FLG_CMPA] = match[0] || ((upd_pc || (timer_tick && mode_pfc && at_top))
                                  && top_from_a);
  assign flag_set[DSP_FLG_CMPB] = match[1];
  assign flag_set[DSP_FLG_CAP]  = timer_tick && at_top && top_from_cap;
  // Set wins over a write-one clear in the same cycle
  assign flags_nxt = (flags_r & ~(wr_flags ? reg_wdata[3:0] : 4'h0)) | flag_set;

  assign rdata_nxt = (reg_addr == DSP_REG_CTRL)   ? ctrl_r :
                     (reg_addr == DSP_REG_CNT)    ? counter_value_r :
                     (reg_addr == DSP_REG_CMPA)   ? cmp_a_buf_r :
                     (reg_addr == DSP_REG_CMPB)   ? cmp_b_buf_r :
                     (reg_addr == DSP_REG_CAPTOP) ? capture_top_value_r :
                     (reg_addr == DSP_REG_FLAGS)  ? {12'h000, flags_r} :
                     (reg_addr == DSP_REG_DIR)    ? {14'h0000, pin_direction_bit_r} :
                     16'h0000;

  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      counter_value_r <= DSP_RST16;
      down_r          <= 1'b0;
    end else if (clk_en && wr_cnt) begin
      counter_value_r <= reg_wdata;
    end else if (clk_en && timer_tick) begin
      counter_value_r <= cnt_nxt;
      down_r          <= down_nxt;
    end
  end

  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      ctrl_r              <= DSP_RST16;
      capture_top_value_r <= DSP_RST16;
      pin_direction_bit_r <= 2'h0;
      flags_r             <= 4'h0;
      oc_r                <= 2'h0;
    end else if (clk_en) begin
      if (wr_ctrl) ctrl_r <= {5'h00, reg_wdata[10:0]};
      if (wr_cap) capture_top_value_r <= reg_wdata;
      if (wr_dir) pin_direction_bit_r <= reg_wdata[1:0];
      flags_r <= flags_nxt;
      oc_r    <= oc_nxt;
    end
  end

  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      cmp_a_buf_r       <= DSP_RST16;
      cmp_b_buf_r       <= DSP_RST16;
      compare_a_value_r <= DSP_RST16;
      compare_b_value_r <= DSP_RST16;
    end else if (clk_en) begin
      if (wr_cmpa) cmp_a_buf_r <= reg_wdata & wmask;
      if (wr_cmpb) cmp_b_buf_r <= reg_wdata & wmask;
      // buffered load; outside dual modes follow buffer directly
      if (upd || !dual) begin
        compare_a_value_r <= cmp_a_buf_r;
        compare_b_value_r <= cmp_b_buf_r;
      end
    end
  end

  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      reg_rdata_r <= DSP_RST16;
      oc_a_pin_r  <= 1'b0;
      oc_b_pin_r  <= 1'b0;
      oe_a_r      <= 1'b0;
      oe_b_r      <= 1'b0;
    end else if (clk_en) begin
      reg_rdata_r <= reg_rd ? rdata_nxt : DSP_RST16;
      oc_a_pin_r  <= oc_nxt[0];
      oc_b_pin_r  <= oc_nxt[1];
      oe_a_r      <= pin_direction_bit_r[0] && conn[0] && dual;
      oe_b_r      <= pin_direction_bit_r[1] && conn[1] && dual;
    end
  end

  assign reg_rdata           = reg_rdata_r;
  assign compare_output_a    = oc_a_pin_r;
  assign compare_output_b    = oc_b_pin_r;
  assign compare_output_a_oe = oe_a_r;
  assign compare_output_b_oe = oe_b_r;
endmodule : dsp_timer

// [test/dsp_timer_properties.sv]
module dsp_timer_checker
  import dsp_pkg::*;
(
  input wire logic        ref_clk,
  input wire logic        resetn,
  input wire logic        clk_en,
  input wire logic [3:0]  reg_addr,
  input wire logic [15:0] reg_wdata,
  input wire logic        reg_wr,
  input wire logic        reg_rd,
  input wire logic [15:0] reg_rdata,
  input wire logic        compare_output_a,
  input wire logic        compare_output_a_oe,
  input wire logic        compare_output_b,
  input wire logic        compare_output_b_oe
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!resetn);
  logic [15:0] ctrl_r, cmpa_r, cmpb_r, cap_r, mask_w;
  logic [1:0]  dir_r;
  logic [3:0]  wgm_w;
  logic        dual_w, con_a_w, con_b_w, rd_w;
  assign wgm_w = ctrl_r[DSP_CTRL_WGM_LSB +: 4];
  assign rd_w = reg_rd && clk_en;
  // Fixed TOP narrows the compare word when it is written
  assign mask_w = wgm_w == DSP_WGM_PC8 ? DSP_TOP8 : wgm_w == DSP_WGM_PC9 ? DSP_TOP9 :
                  wgm_w == DSP_WGM_PC10 ? DSP_TOP10 : 16'hFFFF;
  assign dual_w = wgm_w inside {4'h1, 4'h2, 4'h3, 4'h8, 4'h9, 4'hA, 4'hB};
  // Toggle connects channel A only where A defines TOP
  assign con_a_w = dir_r[0] && dual_w && (ctrl_r[DSP_CTRL_COMA_LSB + 1] ||
                   (ctrl_r[DSP_CTRL_COMA_LSB] && wgm_w[3] && wgm_w[0]));
  assign con_b_w = dir_r[1] && dual_w && ctrl_r[DSP_CTRL_COMB_LSB + 1];
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      ctrl_r <= 16'h0000;
      cmpa_r <= 16'h0000;
      cmpb_r <= 16'h0000;
      cap_r  <= 16'h0000;
      dir_r  <= 2'h0;
    end else if (reg_wr && clk_en) begin
      if (reg_addr == DSP_REG_CTRL) ctrl_r <= reg_wdata;
      if (reg_addr == DSP_REG_CMPA) cmpa_r <= reg_wdata & mask_w;
      if (reg_addr == DSP_REG_CMPB) cmpb_r <= reg_wdata & mask_w;
      if (reg_addr == DSP_REG_CAPTOP) cap_r <= reg_wdata;
      if (reg_addr == DSP_REG_DIR) dir_r <= reg_wdata[1:0];
    end
  end
  read_idle_a: assert property (clk_en && !reg_rd |=> reg_rdata == 16'h0000)
    else $error("read data not zero when idle");
  read_unmapped_a: assert property (rd_w && reg_addr > DSP_REG_DIR |=> reg_rdata == 16'h0000)
    else $error("unmapped read not zero");
  read_captop_a: assert property (rd_w && reg_addr == DSP_REG_CAPTOP |=> reg_rdata == cap_r)
    else $error("capture top read mismatch");
  read_cmpa_a: assert property (rd_w && reg_addr == DSP_REG_CMPA |=> reg_rdata == cmpa_r)
    else $error("compare a read mismatch");
  read_cmpb_a: assert property (rd_w && reg_addr == DSP_REG_CMPB |=> reg_rdata == cmpb_r)
    else $error("compare b read mismatch");
  read_dir_a: assert property (rd_w && reg_addr == DSP_REG_DIR |=> reg_rdata == {14'h0, dir_r})
    else $error("direction read mismatch");
  pin_a_gate_a: assert property (compare_output_a_oe |-> $past(con_a_w) || $past(con_a_w, 2))
    else $error("pin a driven while disconnected");
  pin_b_gate_a: assert property (compare_output_b_oe |-> $past(con_b_w) || $past(con_b_w, 2))
    else $error("pin b driven while disconnected");
  pin_a_drive_a: assert property ($past(con_a_w) && $past(con_a_w, 2) |-> compare_output_a_oe)
    else $error("pin a not driven");
  pin_b_drive_a: assert property ($past(con_b_w) && $past(con_b_w, 2) |-> compare_output_b_oe)
    else $error("pin b not driven");
  cover property (compare_output_a_oe && $rose(compare_output_a));
  cover property (rd_w && reg_addr == DSP_REG_FLAGS);
  cover property (compare_output_b_oe && $fell(compare_output_b));
endmodule : dsp_timer_checker

bind dsp_timer dsp_timer_checker u_checker (.ref_clk(ref_clk), .resetn(resetn), .clk_en(clk_en),
  .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
  .reg_rdata(reg_rdata), .compare_output_a(compare_output_a),
  .compare_output_a_oe(compare_output_a_oe), .compare_output_b(compare_output_b),
  .compare_output_b_oe(compare_output_b_oe));

// [test/dual_slope_pwm_timer_test.sv]
module dual_slope_pwm_timer_test
  import dsp_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  logic        ref_clk = 1'b0;
  logic        resetn = 1'b0;
  logic        clk_en = 1'b1;
  logic [3:0]  reg_addr = 4'h0;
  logic [15:0] reg_wdata = 16'h0000;
  logic        reg_wr = 1'b0;
  logic        reg_rd = 1'b0;
  logic [15:0] reg_rdata;
  logic        out_a, oe_a, out_b, oe_b, rd_pend = 1'b0;
  logic [16:0] exp_q[$];
  logic [16:0] mon_e;
  logic [15:0] samp[$];
  logic [15:0] rnd = 16'h004D;
  int          bad_count = 0;
  int          checks = 0;
  logic [3:0]  wl[5] = '{4'h0, 4'h1, 4'h2, 4'h3, 4'h8};
  logic [15:0] ml[5] = '{16'hFFFF, 16'h00FF, 16'h01FF, 16'h03FF, 16'hFFFF};
  logic [3:0]  fw[8] = '{4'hA, 4'hA, 4'h8, 4'hB, 4'h9, 4'h1, 4'h2, 4'h3};
  logic [15:0] ft[8] = '{16'h8, 16'h8, 16'h8, 16'h6, 16'h6, 16'hFF, 16'h1FF, 16'h3FF};
  logic [15:0] fa[8] = '{16'h3, 16'h9, 16'h3, 16'h6, 16'h6, 16'h3, 16'h3, 16'h3};
  logic [15:0] ff[8] = '{16'hF, 16'hD, 16'hF, 16'h7, 16'h7, 16'h7, 16'h7, 16'h7};
  int          dv[6] = '{0, 1, 8, 64, 256, 1024};
  logic [3:0]  ow[9] = '{4'hA, 4'hA, 4'hA, 4'hA, 4'hA, 4'hA, 4'hB, 4'h9, 4'hA};
  logic [1:0]  oc[9] = '{2'h1, 2'h2, 2'h2, 2'h3, 2'h3, 2'h3, 2'h1, 2'h1, 2'h2};
  logic [15:0] oa[9] = '{16'h3, 16'h3, 16'h8, 16'h3, 16'h0, 16'h8, 16'h6, 16'h6, 16'h0};
  int          oh[9] = '{0, 12, 32, 20, 32, 0, 12, 12, 0};

  dsp_timer DUT (.ref_clk(ref_clk), .resetn(resetn), .clk_en(clk_en), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .compare_output_a(out_a), .compare_output_a_oe(oe_a), .compare_output_b(out_b),
    .compare_output_b_oe(oe_b));

  initial begin
    forever #25 ref_clk = ~ref_clk;
  end

  function automatic logic [15:0] lfsr(input logic [15:0] x);
    return {x[14:0], x[15] ^ x[13] ^ x[12] ^ x[10]};
  endfunction : lfsr

  task automatic check(input logic [15:0] got, input logic [15:0] exp);
    checks++;
    if (got !== exp) begin
      bad_count++;
      $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    end
  endtask : check

  // Strobes are driven every cycle so none is assigned twice per step
  task automatic bus(input logic w, input logic r, input logic [3:0] a, input logic [15:0] d,
                     input logic [16:0] e);
    reg_wr <= w;
    reg_rd <= r;
    reg_addr <= a;
    reg_wdata <= d;
    if (r) exp_q.push_back(e);
    @(posedge ref_clk);
  endtask : bus

  task automatic wr(input logic [3:0] a, input logic [15:0] d);
    bus(1'b1, 1'b0, a, d, 17'h0);
  endtask : wr

  task automatic rd(input logic [3:0] a, input logic [15:0] e);
    bus(1'b0, 1'b1, a, 16'h0000, {1'b0, e});
  endtask : rd

  task automatic idle(input int n);
    repeat (n) bus(1'b0, 1'b0, 4'h0, 16'h0000, 17'h0);
  endtask : idle

  task automatic sample(input int n);
    repeat (n) bus(1'b0, 1'b1, DSP_REG_CNT, 16'h0000, 17'h10000);
    idle(2);
  endtask : sample

  // TOP changed while stopped
  // Stopped, non-dual mode first so compare buffers copy straight through
  task automatic setup(input logic [15:0] ctrl, input logic [15:0] ca, input logic [15:0] top);
    wr(DSP_REG_CTRL, 16'h0000);
    wr(DSP_REG_CNT, 16'h0000);
    wr(DSP_REG_CMPA, ca);
    wr(DSP_REG_CMPB, 16'h0005);
    wr(DSP_REG_CAPTOP, top);
    wr(DSP_REG_DIR, 16'h0003);
    wr(DSP_REG_FLAGS, 16'h000F);
    wr(DSP_REG_CTRL, ctrl);
  endtask : setup

  task automatic shape(input logic [15:0] top);
    logic up;
    int   hits;
    hits = 0;
    up = samp[1] > samp[0];
    for (int i = 1; i + 1 < samp.size(); i++) begin
      if (samp[i] == top) begin
        up = 1'b0;
        hits++;
      end
      if (samp[i] == 16'h0000) up = 1'b1;
      check(samp[i + 1], up ? samp[i] + 16'h0001 : samp[i] - 16'h0001);
    end
    check(16'(hits > 0), 16'h0001);
    samp.delete();
  endtask : shape

  task automatic finish_test;
    $display("checks %0d mismatches %0d", checks, bad_count);
    if (bad_count == 0 && checks > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : finish_test

  always @(posedge ref_clk) begin
    rd_pend <= reg_rd;
    if (rd_pend && exp_q.size() > 0) begin
      mon_e = exp_q.pop_front();
      if (mon_e[16]) samp.push_back(reg_rdata);
      else check(reg_rdata, mon_e[15:0]);
    end
  end

  initial begin
    repeat (100000) @(posedge ref_clk);
    bad_count++;
    $display("[FAIL] %0t run did not finish", $time);
    finish_test();
  end

  initial begin
    int n;
    int nb;
    int t;
    logic eo;
    repeat (4) @(posedge ref_clk);
    resetn <= 1'b1;
    for (int i = 0; i < 5; i++) begin
      rnd = lfsr(rnd);
      wr(DSP_REG_CTRL, {12'h000, wl[i]});
      wr(DSP_REG_CMPA, rnd);
      wr(DSP_REG_CMPB, ~rnd);
      wr(DSP_REG_CAPTOP, rnd);
      rd(DSP_REG_CMPA, rnd & ml[i]);
      rd(DSP_REG_CMPB, ~rnd & ml[i]);
      rd(DSP_REG_CAPTOP, rnd);
    end
    wr(4'hF, 16'hFFFF);
    wr(DSP_REG_DIR, 16'h0003);
    rd(4'hF, 16'h0000);
    rd(DSP_REG_DIR, 16'h0003);
    idle(2);
    $display("register test done");
    // TOP at least 3, above compare B; compare A may equal or exceed it
    for (int i = 0; i < 8; i++) begin
      setup({5'h00, 3'h1, 4'hA, fw[i]}, fa[i], ft[i]);
      idle(3);
      sample(2 * ft[i] + 4);
      shape(ft[i]);
      rd(DSP_REG_FLAGS, ff[i]);
      idle(2);
    end
    $display("counting and flag test done");
    for (int p = 0; p < 6; p++) begin
      setup({5'h00, 3'(p), 4'hA, 4'hA}, 16'h0003, 16'h0008);
      idle(1030);
      sample(2049);
      n = 0;
      for (int i = 0; i < 2048; i++) if (samp[i + 1] != samp[i]) n++;
      check(16'(n), p == 0 ? 16'h0000 : 16'(2048 / dv[p]));
      samp.delete();
    end
    $display("prescale test done");
    for (int i = 0; i < 9; i++) begin
      t = ow[i] == 4'hA ? 8 : 6;
      setup({5'h00, 3'h1, oc[i], oc[i], ow[i]}, oa[i], 16'h0008);
      idle(2 * t + 4);
      n = 0;
      nb = 0;
      for (int k = 0; k < 4 * t; k++) begin
        idle(1);
        n += int'(out_a === 1'b1);
        nb += int'(out_b === 1'b1);
      end
      eo = oc[i][1] || (ow[i][3] && ow[i][0]);
      check(16'(oe_a), 16'(eo));
      check(16'(oe_b), 16'(oc[i][1]));
      if (eo) check(16'(n), 16'(oh[i]));
      if (oc[i][1]) check(16'(nb), oc[i][0] ? 16'h000C : 16'h0014);
    end
    wr(DSP_REG_DIR, 16'h0000);
    idle(3);
    check(16'(oe_a), 16'h0000);
    check(16'(oe_b), 16'h0000);
    $display("waveform test done");
    finish_test();
  end
endmodule : dual_slope_pwm_timer_test
